// ### verilog/stt_consts.vh
// constants for the trace trigger capture sequencer
`ifndef STT_CONSTS_VH
`define STT_CONSTS_VH
`define STT_OFF_CTRL      12'h000
`define STT_OFF_TRIG      12'h004
`define STT_OFF_PAT       12'h008
`define STT_OFF_STAT      12'h00C
`define STT_OFF_ADDR      12'h010
`define STT_OFF_IRQ       12'h014
`define STT_OFF_MASK      12'h018
`define STT_MODE_NONE     2'h0
`define STT_MODE_PRE      2'h1
`define STT_MODE_POST     2'h2
`define STT_DLY_NONE      2'h0
`define STT_DLY_IDLE      2'h1
`define STT_DLY_SHORT     2'h2
`define STT_DLY_LONG      2'h3
`define STT_SHORT_EVENTS  64
`define STT_LONG_EVENTS   2048
`define STT_ID_PAT_RST    8'h84
`define STT_STATUS_RST    8'h02
`define STT_MSG_RST       8'h0B
`define STT_CMD_RST       8'h12
`define STT_IRQ_TRIG      0
`define STT_IRQ_DONE      1
`define STT_IRQ_WRAP      2
`define STT_IRQ_W         3
`endif

// ### verilog/stt_match.v
// trigger comparator for message, command and status codes with id gating
`timescale 1ns/1ps
`default_nettype none
module stt_match (
   input  wire       pclk,
   input  wire       presetn,
   input  wire       ev_valid,
   input  wire       ev_bus_free,
   input  wire       ev_select,
   input  wire       ev_msg,
   input  wire       ev_cmd,
   input  wire       ev_status,
   input  wire [7:0] ev_data,
   input  wire [7:0] id_pat,
   input  wire       id_en,
   input  wire       msg_en,
   input  wire       cmd_en,
   input  wire       stat_en,
   input  wire       comb_and,
   input  wire [7:0] msg_code,
   input  wire [7:0] cmd_code,
   input  wire [7:0] stat_code,
   output wire       hit
);
   reg  id_ok_q;
   reg  cmd_seen_q;
   wire id_gate;
   wire msg_hit;
   wire cmd_hit;
   wire stat_hit;

   // id seen during the last selection, forgotten at bus free
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         id_ok_q    <= 1'b0;
         cmd_seen_q <= 1'b0;
      end else if (ev_valid) begin
         if (ev_bus_free) begin
            id_ok_q    <= 1'b0;
            cmd_seen_q <= 1'b0;
         end else if (ev_select) begin
            id_ok_q <= ((ev_data & id_pat) == id_pat);
         end else if (cmd_hit) begin
            cmd_seen_q <= 1'b1;
         end
      end
   end

   assign id_gate  = !id_en || id_ok_q;
   assign msg_hit  = ev_valid && msg_en && ev_msg && (ev_data == msg_code)
                     && id_gate;
   assign cmd_hit  = ev_valid && cmd_en && ev_cmd && (ev_data == cmd_code)
                     && id_gate;
   assign stat_hit = ev_valid && stat_en && ev_status
                     && (ev_data == stat_code) && id_gate;
   // and-combine needs the command seen earlier in the same command
   assign hit = msg_hit ||
                ((cmd_en && stat_en && comb_and) ? (stat_hit && cmd_seen_q)
                                                 : (cmd_hit || stat_hit));
endmodule // stt_match
`default_nettype wire

// ### verilog/stt_capture.v
// trace capture sequencer with trigger modes and apb register slave
//
// Functional notes
// - post mode records and wraps before trigger
// - idle delay stops at next bus free
// - report last address when trigger ends
// - id pattern is one bit per id
// - status code compare against programmed value
// - pre mode waits for message code match
// - pre trace keeps command from bus free
// - pre mode stops when memory full after trigger
// - operator stop halts tracing at once
// - no trigger records and wraps until stop
// - stop reports max address after wrap without trigger
// - pre mode rewinds address at bus free before trigger
// - short delay records 64 more events
// - long delay records 2048 more events
// - id gating requires pattern at selection
`timescale 1ns/1ps
`default_nettype none
`include "stt_consts.vh"
module stt_capture #(
   parameter AW          = 15,
   parameter SHORT_COUNT = `STT_SHORT_EVENTS,
   parameter LONG_COUNT  = `STT_LONG_EVENTS
) (
   input  wire          pclk,
   input  wire          presetn,
   input  wire          psel,
   input  wire          penable,
   input  wire          pwrite,
   input  wire [11:0]   paddr,
   input  wire [31:0]   pwdata,
   output reg  [31:0]   prdata,
   output wire          pready,
   output wire          pslverr,
   input  wire          ev_valid_pin,
   input  wire          ev_bus_free_pin,
   input  wire          ev_select_pin,
   input  wire          ev_msg_pin,
   input  wire          ev_cmd_pin,
   input  wire          ev_status_pin,
   input  wire [7:0]    ev_data_pin,
   output reg           trace_we,
   output reg  [AW-1:0] trace_addr,
   output reg  [15:0]   trace_wdata,
   output wire          tracing,
   output wire          irq
);
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_RUN  = 3'b010;
   localparam [2:0] ST_DLY  = 3'b100;
   localparam [AW-1:0] ADDR_MAX = {AW{1'b1}};

   reg [2:0]    state_q;
   reg [AW-1:0] addr_q;
   reg [AW-1:0] last_q;
   reg          trig_q;
   reg          wrap_q;
   reg          hit_done_q;
   reg [11:0]   dly_q;
   reg [1:0]    mode_q;
   reg [1:0]    dly_sel_q;
   reg          id_en_q;
   reg          msg_en_q;
   reg          cmd_en_q;
   reg          stat_en_q;
   reg          and_q;
   reg [7:0]    id_pat_q;
   reg [7:0]    msg_code_q;
   reg [7:0]    cmd_code_q;
   reg [7:0]    stat_code_q;
   reg [`STT_IRQ_W-1:0] irq_q;
   reg [`STT_IRQ_W-1:0] mask_q;
   reg [13:0]   s1_q;
   reg [13:0]   s2_q;
   reg [13:0]   v_q;

   ////////////////////////////////////////////////////////////////////
   // two-stage synchroniser, then a register to catch the strobe edge
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= 14'h0000;
         s2_q <= 14'h0000;
         v_q  <= 14'h0000;
      end else begin
         s1_q <= {ev_data_pin, ev_status_pin, ev_cmd_pin, ev_msg_pin,
                  ev_select_pin, ev_bus_free_pin, ev_valid_pin};
         s2_q <= s1_q;
         v_q  <= s2_q;
      end
   end

   // one event per rising edge of the valid strobe
   wire       ev      = s2_q[0] && !v_q[0];
   wire       ev_free = s2_q[1];
   wire [7:0] ev_data = s2_q[13:6];
   wire       hit;

   stt_match u_match (
      .pclk        (pclk),
      .presetn     (presetn),
      .ev_valid    (ev),
      .ev_bus_free (ev_free),
      .ev_select   (s2_q[2]),
      .ev_msg      (s2_q[3]),
      .ev_cmd      (s2_q[4]),
      .ev_status   (s2_q[5]),
      .ev_data     (ev_data),
      .id_pat      (id_pat_q),
      .id_en       (id_en_q),
      .msg_en      (msg_en_q),
      .cmd_en      (cmd_en_q),
      .stat_en     (stat_en_q),
      .comb_and    (and_q),
      .msg_code    (msg_code_q),
      .cmd_code    (cmd_code_q),
      .stat_code   (stat_code_q),
      .hit         (hit)
   );

   ////////////////////////////////////////////////////////////////////
   // apb decode; zero wait states, unmapped address answers slverr
   wire wr = psel && penable && pwrite;
   wire rd_sel = (paddr == `STT_OFF_CTRL) || (paddr == `STT_OFF_TRIG) ||
                 (paddr == `STT_OFF_PAT)  || (paddr == `STT_OFF_STAT) ||
                 (paddr == `STT_OFF_ADDR) || (paddr == `STT_OFF_IRQ)  ||
                 (paddr == `STT_OFF_MASK);
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !rd_sel;
   wire run_cmd  = wr && (paddr == `STT_OFF_CTRL) && pwdata[0];
   wire stop_cmd = wr && (paddr == `STT_OFF_CTRL) && pwdata[1];

   ////////////////////////////////////////////////////////////////////
   // sequencer
   wire store   = ev && (state_q != ST_IDLE);
   // in pre mode, before the trigger a bus free restarts the command at address zero,
   // so the whole triggering command is kept from its bus free on
   wire rewind  = ev_free && !trig_q && !hit &&
                  (mode_q == `STT_MODE_PRE);
   wire [AW-1:0] slot = rewind ? {AW{1'b0}} : addr_q;
   wire at_top  = (slot == ADDR_MAX);
   wire [11:0] dly_load = (dly_sel_q == `STT_DLY_LONG) ?
                          LONG_COUNT[11:0] - 12'h001 :
                          SHORT_COUNT[11:0] - 12'h001;
   reg  [2:0]    state_d;
   reg  [AW-1:0] addr_d;
   reg           end_d;
   reg           trig_d;
   reg           wrap_d;

   always @* begin
      state_d = state_q;
      addr_d  = addr_q;
      end_d   = 1'b0;
      trig_d  = trig_q;
      wrap_d  = wrap_q;
      case (state_q)
         ST_IDLE: begin
            if (run_cmd) begin
               state_d = ST_RUN;
               addr_d  = {AW{1'b0}};
               trig_d  = 1'b0;
               wrap_d  = 1'b0;
            end
         end
         ST_RUN: begin
            if (store) begin
               addr_d = slot + {{(AW-1){1'b0}}, 1'b1};
               if (at_top)
                  wrap_d = 1'b1;
               if (mode_q == `STT_MODE_PRE) begin
                  if (hit && !trig_q)
                     trig_d = 1'b1;
                  if ((trig_q || hit) && at_top) begin
                     state_d = ST_IDLE;
                     end_d   = 1'b1;
                  end
               end else if (mode_q == `STT_MODE_POST && hit) begin
                  trig_d = 1'b1;
                  if (dly_sel_q == `STT_DLY_NONE) begin
                     state_d = ST_IDLE;
                     end_d   = 1'b1;
                  end else
                     state_d = ST_DLY;
               end
            end
         end
         ST_DLY: begin
            if (store) begin
               addr_d = addr_q + {{(AW-1){1'b0}}, 1'b1};
               if (at_top)
                  wrap_d = 1'b1;
               if (dly_sel_q == `STT_DLY_IDLE) begin
                  if (ev_free) begin
                     state_d = ST_IDLE;
                     end_d   = 1'b1;
                  end
               end else if (dly_q == 12'h000) begin
                  state_d = ST_IDLE;
                  end_d   = 1'b1;
               end
            end
         end
         default: state_d = ST_IDLE;
      endcase
      if (stop_cmd && state_q != ST_IDLE) begin
         state_d = ST_IDLE;
         end_d   = 1'b1;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q     <= ST_IDLE;
         addr_q      <= {AW{1'b0}};
         last_q      <= {AW{1'b0}};
         trig_q      <= 1'b0;
         wrap_q      <= 1'b0;
         hit_done_q  <= 1'b0;
         dly_q       <= 12'h000;
         trace_we    <= 1'b0;
         trace_addr  <= {AW{1'b0}};
         trace_wdata <= 16'h0000;
      end else begin
         state_q  <= state_d;
         addr_q   <= addr_d;
         trig_q   <= trig_d;
         wrap_q   <= wrap_d;
         trace_we <= store && !(stop_cmd);
         if (store) begin
            trace_addr  <= slot;
            trace_wdata <= {2'b00, s2_q[5:0], ev_data};
         end
         if (state_q == ST_RUN && state_d == ST_DLY)
            dly_q <= dly_load;
         else if (state_q == ST_DLY && store && dly_q != 12'h000)
            dly_q <= dly_q - 12'h001;
         if (end_d) begin
            // wrapped memory without a trigger reports the top address
            if (wrap_d && !trig_d)
               last_q <= ADDR_MAX;
            else if (store)
               last_q <= slot;
            else
               last_q <= addr_q - {{(AW-1){1'b0}}, 1'b1};
            hit_done_q <= trig_d;
         end else if (run_cmd && state_q == ST_IDLE)
            hit_done_q <= 1'b0;
      end
   end

   assign tracing = (state_q != ST_IDLE);

   ////////////////////////////////////////////////////////////////////
   // configuration and interrupt registers
   wire [`STT_IRQ_W-1:0] irq_set;
   assign irq_set[`STT_IRQ_TRIG] = trig_d && !trig_q;
   assign irq_set[`STT_IRQ_DONE] = end_d;
   assign irq_set[`STT_IRQ_WRAP] = wrap_d && !wrap_q;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q      <= `STT_MODE_NONE;
         dly_sel_q   <= `STT_DLY_NONE;
         id_en_q     <= 1'b0;
         msg_en_q    <= 1'b0;
         cmd_en_q    <= 1'b0;
         stat_en_q   <= 1'b0;
         and_q       <= 1'b0;
         id_pat_q    <= `STT_ID_PAT_RST;
         msg_code_q  <= `STT_MSG_RST;
         cmd_code_q  <= `STT_CMD_RST;
         stat_code_q <= `STT_STATUS_RST;
         irq_q       <= {`STT_IRQ_W{1'b0}};
         mask_q      <= {`STT_IRQ_W{1'b0}};
      end else begin
         if (wr && paddr == `STT_OFF_TRIG) begin
            mode_q    <= pwdata[1:0];
            dly_sel_q <= pwdata[3:2];
            id_en_q   <= pwdata[4];
            msg_en_q  <= pwdata[5];
            cmd_en_q  <= pwdata[6];
            stat_en_q <= pwdata[7];
            and_q     <= pwdata[8];
         end
         if (wr && paddr == `STT_OFF_PAT) begin
            id_pat_q    <= pwdata[7:0];
            msg_code_q  <= pwdata[15:8];
            cmd_code_q  <= pwdata[23:16];
            stat_code_q <= pwdata[31:24];
         end
         if (wr && paddr == `STT_OFF_MASK)
            mask_q <= pwdata[`STT_IRQ_W-1:0];
         // set wins over write-one-to-clear
         if (wr && paddr == `STT_OFF_IRQ)
            irq_q <= (irq_q & ~pwdata[`STT_IRQ_W-1:0]) | irq_set;
         else
            irq_q <= irq_q | irq_set;
      end
   end

   assign irq = |(irq_q & mask_q);

   always @* begin
      prdata = 32'h00000000;
      if (paddr == `STT_OFF_TRIG)
         prdata = {23'h000000, and_q, stat_en_q, cmd_en_q, msg_en_q,
                   id_en_q, dly_sel_q, mode_q};
      else if (paddr == `STT_OFF_PAT)
         prdata = {stat_code_q, cmd_code_q, msg_code_q, id_pat_q};
      else if (paddr == `STT_OFF_STAT)
         prdata = {28'h0000000, hit_done_q, wrap_q, trig_q, tracing};
      else if (paddr == `STT_OFF_ADDR)
         prdata = {{(32-AW){1'b0}}, last_q};
      else if (paddr == `STT_OFF_IRQ)
         prdata = {{(32-`STT_IRQ_W){1'b0}}, irq_q};
      else if (paddr == `STT_OFF_MASK)
         prdata = {{(32-`STT_IRQ_W){1'b0}}, mask_q};
   end
endmodule // stt_capture
`default_nettype wire

// ### tb/stt_capture_asserts.sv
// port checker for the trace capture sequencer
`timescale 1ns/1ps
`default_nettype none
`include "stt_consts.vh"
module stt_capture_asserts #(
   parameter AW = 15
) (
   input wire logic          pclk,
   input wire logic          presetn,
   input wire logic          psel,
   input wire logic          penable,
   input wire logic          pwrite,
   input wire logic [11:0]   paddr,
   input wire logic [31:0]   pwdata,
   input wire logic [31:0]   prdata,
   input wire logic          trace_we,
   input wire logic [AW-1:0] trace_addr,
   input wire logic          tracing,
   input wire logic          irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic          wr_ok;
   logic [AW-1:0] last_q;
   assign wr_ok = psel && penable && pwrite;
   // all ones so the first word at address zero counts as one step
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_q <= '1;
      end else if (trace_we) begin
         last_q <= trace_addr;
      end
   end
   sequence s_run;
      wr_ok && paddr == `STT_OFF_CTRL && pwdata[1:0] == 2'h1 && !tracing;
   endsequence
   sequence s_stop;
      wr_ok && paddr == `STT_OFF_CTRL && pwdata[1];
   endsequence
   AST_RUN_STARTS: assert property (s_run |=> tracing)
      else $error("run write did not start tracing");
   AST_STOP_HALTS: assert property (s_stop |=> !tracing)
      else $error("stop write did not halt tracing");
   AST_IDLE_QUIET: assert property (!tracing [*4] |=> !trace_we)
      else $error("trace word written while idle");
   AST_WE_SPACING: assert property (trace_we |=> !trace_we [*5])
      else $error("trace write pulse too long or doubled");
   AST_ADDR_STEP: assert property (trace_we |->
      trace_addr == last_q + 1'b1 || trace_addr == '0)
      else $error("trace address skipped");
   AST_STAT_TRACING: assert property (psel && !pwrite &&
      paddr == `STT_OFF_STAT |-> prdata[0] == tracing)
      else $error("status tracing bit disagrees with pin");
   AST_CTRL_ZERO: assert property (psel && !pwrite &&
      paddr == `STT_OFF_CTRL |-> prdata == 32'h0)
      else $error("control register read not zero");
   AST_MASK_QUIET: assert property (wr_ok && paddr == `STT_OFF_MASK &&
      pwdata[2:0] == 3'h0 |=> !irq)
      else $error("interrupt high with all sources masked");
endmodule // stt_capture_asserts
bind stt_capture stt_capture_asserts #(.AW(AW)) stt_capture_asserts_inst (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .trace_we(trace_we), .trace_addr(trace_addr), .tracing(tracing),
   .irq(irq));
`default_nettype wire

// ### tb/stt_bus_model.sv
// behavioural source of monitored bus events
`timescale 1ns/1ps
`default_nettype none
module stt_bus_model (
   input  wire logic       pclk,
   output var  logic       ev_valid,
   output var  logic [4:0] ev_kind,
   output var  logic [7:0] ev_data
);
   initial begin
      ev_valid = 1'b0;
      ev_kind = 5'h00;
      ev_data = 8'h00;
   end
   // kind is {status, command, message, select, bus free}
   task automatic send(input logic [4:0] k, input logic [7:0] d,
                       input int gap);
      @(posedge pclk);
      ev_kind <= k;
      ev_data <= d;
      @(posedge pclk);
      ev_valid <= 1'b1;
      repeat (3) @(posedge pclk);
      ev_valid <= 1'b0;
      repeat (3 + gap) @(posedge pclk);
      // released lines float: show the inverse, never stale data
      ev_kind <= ~k;
      ev_data <= ~d;
   endtask
endmodule // stt_bus_model
`default_nettype wire

// ### tb/stt_capture_bench.sv
// self-checking bench for the trace capture sequencer
`timescale 1ns/1ps
`default_nettype none
`include "stt_consts.vh"
module stt_capture_bench;
   localparam logic [4:0] BF = 5'h01, SEL = 5'h02, MSG = 5'h04;
   localparam logic [4:0] CMD = 5'h08, STS = 5'h10;
   logic        pclk = 1'b0, presetn = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic        pready, pslverr, trace_we, tracing, irq, ev_valid;
   logic [3:0]  trace_addr, a;
   logic [15:0] trace_wdata;
   logic [4:0]  ev_kind;
   logic [7:0]  ev_data, lf = 8'h5E;
   logic [17:0] nt;
   logic [32:0] rq[$];
   logic [17:0] tq[$];
   int          err_total = 0, check_count = 0;
   initial begin
      forever #5 pclk = ~pclk;
   end
   stt_bus_model bus_inst (.pclk(pclk), .ev_valid(ev_valid),
      .ev_kind(ev_kind), .ev_data(ev_data));
   stt_capture #(.AW(4), .SHORT_COUNT(4), .LONG_COUNT(8)) stt_capture_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ev_valid_pin(ev_valid),
      .ev_bus_free_pin(ev_kind[0]), .ev_select_pin(ev_kind[1]),
      .ev_msg_pin(ev_kind[2]), .ev_cmd_pin(ev_kind[3]),
      .ev_status_pin(ev_kind[4]), .ev_data_pin(ev_data),
      .trace_we(trace_we), .trace_addr(trace_addr),
      .trace_wdata(trace_wdata), .tracing(tracing), .irq(irq));
   ////////////////////////////////////////
   function automatic logic [7:0] rnd();
      lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
      return lf;
   endfunction
   task automatic chk_reg(input logic [32:0] g, input logic [32:0] e);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chk_trace(input logic [19:0] g, input logic [19:0] e);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic pins(input logic t, input logic i);
      @(negedge pclk);
      chk_reg({31'h0, tracing, irq}, {31'h0, t, i});
   endtask
   task automatic apb(input logic w, input logic [11:0] ad,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] ad, input logic [32:0] e);
      rq.push_back(e);
      apb(1'b0, ad, 32'h0);
   endtask
   task automatic start();
      apb(1'b1, `STT_OFF_CTRL, 32'h1);
      a = 4'h0;
   endtask
   // r: 0 not stored, 1 stored at the next address, 2 either way
   task automatic ev(input logic [4:0] k, input logic [7:0] d, input int r);
      if (r != 0) begin
         tq.push_back({r == 2, a, k, d});
         a++;
      end
      bus_inst.send(k, d, int'(rnd() & 8'h03));
   endtask
   task automatic print_verdict();
      err_total += tq.size() + rq.size();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite) begin
         chk_reg({pslverr, prdata},
                 rq.size() != 0 ? rq.pop_front() : 33'hX);
      end
      if (trace_we) begin
         nt = tq.size() != 0 ? tq.pop_front() : 18'hX;
         // stored word is {00, kind bits, strobe, data byte}
         if (nt[17] !== 1'b1) begin
            chk_trace({trace_addr, trace_wdata},
                      {nt[16:13], 2'b00, nt[12:8], 1'b1, nt[7:0]});
         end
      end
   end
   initial begin
      repeat (20000) @(posedge pclk);
      err_total++;
      print_verdict();
   end
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd(`STT_OFF_PAT, {1'b0, 32'h02120B84});
      rd(`STT_OFF_CTRL, 33'h0);
      rd(12'h01C, {1'b1, 32'h0});
      apb(1'b1, `STT_OFF_MASK, 32'h7);
      apb(1'b1, `STT_OFF_TRIG, 32'h0);
      start();
      repeat (18) ev(CMD, rnd(), 1);
      rd(`STT_OFF_IRQ, 33'h4);
      pins(1'b1, 1'b1);
      apb(1'b1, `STT_OFF_CTRL, 32'h2);
      ev(CMD, rnd(), 0);
      rd(`STT_OFF_ADDR, 33'hF);
      rd(`STT_OFF_STAT, 33'h4);
      apb(1'b1, `STT_OFF_MASK, 32'h0);
      pins(1'b0, 1'b0);
      apb(1'b1, `STT_OFF_IRQ, 32'h7);
      apb(1'b1, `STT_OFF_MASK, 32'h7);
      pins(1'b0, 1'b0);
      apb(1'b1, `STT_OFF_TRIG, 32'h21);
      start();
      ev(BF, 8'h00, 1);
      ev(SEL, 8'h84, 1);
      ev(MSG, 8'h04, 1);
      a = 4'h0;
      ev(BF, 8'h00, 1);
      ev(SEL, 8'h84, 1);
      ev(MSG, 8'h0B, 1);
      ev(BF, 8'h00, 1);
      repeat (12) ev(CMD, rnd(), 1);
      ev(CMD, rnd(), 0);
      rd(`STT_OFF_ADDR, 33'hF);
      for (int dl = 1; dl < 5; dl++) begin
         apb(1'b1, `STT_OFF_TRIG, 32'h92 | (32'(dl % 4) << 2));
         start();
         repeat (18) ev(CMD, rnd(), 1);
         ev(BF, 8'h00, 1);
         ev(SEL, 8'h80, 1);
         ev(STS, 8'h02, 1);
         ev(BF, 8'h00, 1);
         ev(SEL, 8'h84, 1);
         ev(STS, 8'h02, dl == 4 ? 2 : 1);
         if (dl == 1) begin
            ev(CMD, rnd(), 1);
            ev(BF, 8'h00, 2);
         end
         repeat (dl == 2 ? 4 : dl == 3 ? 8 : 0) ev(CMD, rnd(), 1);
         ev(CMD, rnd(), 0);
         pins(1'b0, 1'b1);
         if (dl == 2 || dl == 3) begin
            rd(`STT_OFF_ADDR, {29'h0, a - 4'h1});
         end else begin
            tq.delete();
         end
      end
      print_verdict();
   end
endmodule // stt_capture_bench
`default_nettype wire
